// ### otpbc_consts.svh
// Offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the top design file and the bench; the package and source model do not include it.
`ifndef OTPBC_CONSTS_SVH
`define OTPBC_CONSTS_SVH
`define OTPBC_IDX_CTRL 14'h0007
`define OTPBC_IDX_OPT 14'h1efe
`define OTPBC_IDX_ARRW 14'h0020
`define OTPBC_IDX_STAT 14'h0021
`define OTPBC_CTRL_PPC 6
`define OTPBC_CTRL_LAT 5
`define OTPBC_CTRL_ARM 4
`define OTPBC_CTRL_CLK 3
`define OTPBC_OPT_PROT 6
`define OTPBC_OPT_HOLD 4
`define OTPBC_OPT_WDR 3
`define OTPBC_OPT_WDW 2
`define OTPBC_OPT_PORT_B_PULLDOWN 1
`define OTPBC_OPT_PORT_C_PULLDOWN 0
`define OTPBC_OPT_WMASK 8'h5f
`define OTPBC_OPT_INIT 8'h00
`define OTPBC_HOLD_SHORT 12'h010
`define OTPBC_HOLD_LONG 12'hfe0
`define OTPBC_CLK_MHZ 125
`define OTPBC_PROG_US 5000
`define OTPBC_PROG_CYC (`OTPBC_PROG_US * `OTPBC_CLK_MHZ)
`define OTPBC_BLINK_HZ 3
`define OTPBC_BLINK_CYC (`OTPBC_CLK_MHZ * 1000000 / (2 * `OTPBC_BLINK_HZ))
`define OTPBC_COPY_CYC 64
`define OTPBC_ARR_LO 13'h0100
`define OTPBC_ARR_HI 13'h1fff
`endif

// ### otpbc_pkg.sv
// Types shared by the programming control block.
// Assumes nothing beyond a SystemVerilog compiler.
package otpbc_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b000,
    MODE_ERASE  = 3'b001,
    MODE_PPROG  = 3'b010,
    MODE_SERIAL = 3'b011,
    MODE_RAMPAR = 3'b100
  } otpbc_mode_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_COPY  = 4'b0001,
    S_REQ   = 4'b0010,
    S_WAIT  = 4'b0011,
    S_PROG  = 4'b0100,
    S_VREQ  = 4'b0101,
    S_VWAIT = 4'b0110,
    S_VCMP  = 4'b0111,
    S_ERD   = 4'b1000,
    S_ECMP  = 4'b1001,
    S_PASS  = 4'b1010,
    S_FAIL  = 4'b1011,
    S_HALT  = 4'b1100
  } otpbc_state_t;
  typedef struct packed {
    logic [12:0] addr;
    logic [31:0] data;
    logic [3:0]  mask;
  } otpbc_prog_t;
endpackage

// ### otpbc_top.sv
// Programming control, option bits, boot mode selection and parallel loader.
// Assumes an APB master on clk_i and an array that answers reads one cycle late.
// Notes on behaviour
// - Control register bit 7 always reads zero.
// - Protect copy reloads from array protect on power-on or external reset.
// - Protect copy stays readable while array reads are blocked by latch enable.
// - With latch set and arm clear, each array write latches the address and one of four bytes.
// - STOP, power-on or external reset clears latch enable.
// - Arm takes effect only with latch set and a byte latched.
// - Writing arm zero with latch set never clears arm; clearing latch clears arm.
// - Option register accepts writes only in bootloader mode.
// - Array protect blocks programming, not reading.
// - Reset pin held low 16 or 4064 cycles after power-on.
// - Watchdog runs after reset when enabled, except in bootstrap.
// - Watchdog halts in WAIT unless watchdog in wait is set.
// - Port pull-downs act on all eight pins only while inputs.
// - No reset alters the option bits.
// - Bootstrap needs high-voltage interrupt pin and capture input high.
// - Straps select erased check, parallel program, serial or RAM load.
// - Bootstrap copies itself to RAM, then raises compare output one.
// - Erased check fails red on a nonzero byte, green on full success.
// - Loader programs upward, skips outside the array, four bytes per pulse.
// - With strap 2 low each programming pulse lasts five milliseconds.
// - Loader drives 13-bit address, takes port A data with two handshake lines.
// - Loader verifies against source, blinks green at 3 Hz while programming.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "otpbc_consts.svh"
module otpbc_top #(
  parameter int PROG_CYC  = `OTPBC_PROG_CYC,
  parameter int PROG_ALT  = `OTPBC_PROG_CYC,
  parameter int BLINK_CYC = `OTPBC_BLINK_CYC,
  parameter int COPY_CYC  = `OTPBC_COPY_CYC
) (
  // Clock and power-on reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // APB slave.
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [15:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Pins and CPU status.
  input  wire logic                 ext_reset_n_i,
  input  wire logic                 irq_hv_i,
  input  wire logic                 capture_input_one_i,
  input  wire logic [2:0]           mode_strap_i,
  input  wire logic                 stop_i,
  input  wire logic                 wait_i,
  input  wire logic [7:0]           ddr_b_i,
  input  wire logic [7:0]           ddr_c_i,
  output logic                      reset_pin_low_o,
  output logic                      watchdog_enable_o,
  output logic                      watchdog_run_o,
  output logic [7:0]                pulldown_b_o,
  output logic [7:0]                pulldown_c_o,
  output otpbc_pkg::otpbc_mode_t    boot_mode_o,
  // Parallel loader link.
  input  wire logic [7:0]           port_a_i,
  input  wire logic                 handshake_line_b_i,
  output logic [12:0]               loader_addr_o,
  output logic                      handshake_line_a_o,
  output logic                      compare_output_one_o,
  output logic                      red_led_o,
  output logic                      green_led_o,
  // Array.
  input  wire logic [7:0]           arr_rdata_i,
  output logic                      arr_read_ok_o,
  output otpbc_pkg::otpbc_prog_t    prog_o,
  output logic                      prog_en_o
);
  ////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    hit = (a[15:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  logic [14:0] sync1;
  logic [14:0] sync2;
  logic        ext_n_s;
  logic        irq_s;
  logic        cap_s;
  logic [2:0]  strap_s;
  logic [7:0]  pa_s;
  logic        hsb_s;
  logic [7:0]  opts = `OTPBC_OPT_INIT;
  logic        holding;
  logic [11:0] hold_cnt;
  logic        sys_rst;
  logic        sys_rst_q;
  logic        any_rst;
  logic        rise;
  logic        strap2_q;
  logic        wd_en;
  logic        ppc;
  logic        lat;
  logic        arm;
  logic        clk_opt;
  logic [12:0] lat_addr;
  logic [31:0] lat_data;
  logic [3:0]  lat_mask;
  logic        ack;
  logic        s_ctrl;
  logic        s_opt;
  logic        s_arrw;
  logic        s_stat;
  logic        wr;
  otpbc_pkg::otpbc_mode_t  mode;
  otpbc_pkg::otpbc_mode_t  next_mode;
  otpbc_pkg::otpbc_state_t st;
  logic [31:0] cnt;
  logic [31:0] blink;
  logic [12:0] addr;
  logic [31:0] buf_d;
  logic        ld_pulse;
  logic        prot;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    sync1 <= {ext_reset_n_i, irq_hv_i, capture_input_one_i, mode_strap_i,
              port_a_i, handshake_line_b_i};
    sync2 <= sync1;
  end
  assign {ext_n_s, irq_s, cap_s, strap_s, pa_s, hsb_s} = sync2;

  assign prot    = opts[`OTPBC_OPT_PROT];
  assign any_rst = rst_i | ~ext_n_s;
  assign sys_rst = any_rst | holding;
  assign rise    = sys_rst_q & ~sys_rst;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      holding  <= 1'b1;
      hold_cnt <= 12'h000;
    end else if (holding) begin
      hold_cnt <= hold_cnt + 12'h001;
      if (hold_cnt + 12'h001 == (opts[`OTPBC_OPT_HOLD] ? `OTPBC_HOLD_SHORT
                                                      : `OTPBC_HOLD_LONG)) begin
        holding <= 1'b0;
      end
    end
  end
  assign reset_pin_low_o = holding;

  always_comb begin
    next_mode = otpbc_pkg::MODE_SINGLE;
    if (irq_s && cap_s) begin
      case (strap_s[2:1])
        2'b00:   next_mode = otpbc_pkg::MODE_PPROG;
        2'b01:   next_mode = strap_s[0] ? otpbc_pkg::MODE_SINGLE
                                        : otpbc_pkg::MODE_ERASE;
        2'b11:   next_mode = otpbc_pkg::MODE_SERIAL;
        2'b10:   next_mode = otpbc_pkg::MODE_RAMPAR;
        default: next_mode = otpbc_pkg::MODE_SINGLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    sys_rst_q <= sys_rst;
    if (rst_i) begin
      mode     <= otpbc_pkg::MODE_SINGLE;
      strap2_q <= 1'b0;
      wd_en    <= 1'b0;
    end else if (sys_rst) begin
      wd_en <= 1'b0;
    end else if (rise) begin
      mode     <= next_mode;
      strap2_q <= strap_s[0];
      wd_en    <= opts[`OTPBC_OPT_WDR] & (next_mode == otpbc_pkg::MODE_SINGLE);
    end
  end
  assign boot_mode_o       = mode;
  assign watchdog_enable_o = wd_en;
  assign watchdog_run_o    = wd_en & (~wait_i | opts[`OTPBC_OPT_WDW]);
  assign pulldown_b_o = {8{opts[`OTPBC_OPT_PORT_B_PULLDOWN]}} & ~ddr_b_i;
  assign pulldown_c_o = {8{opts[`OTPBC_OPT_PORT_C_PULLDOWN]}} & ~ddr_c_i;

  ////////////////////////////////////////////////////////////////////
  assign s_ctrl    = hit(paddr_i, `OTPBC_IDX_CTRL);
  assign s_opt     = hit(paddr_i, `OTPBC_IDX_OPT);
  assign s_arrw    = hit(paddr_i, `OTPBC_IDX_ARRW);
  assign s_stat    = hit(paddr_i, `OTPBC_IDX_STAT);
  assign pready_o  = psel_i & penable_i & ack;
  assign pslverr_o = pready_o & ~(s_ctrl | s_opt | s_arrw | s_stat);
  assign wr        = pready_o & pwrite_i & ~pslverr_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      ack <= psel_i & ~penable_i;
      if (psel_i && !penable_i) begin
        prdata_o <= 32'h0000_0000;
        if (s_ctrl) begin
          prdata_o[7:0] <= {1'b0, ppc, lat, arm, clk_opt, 3'b000};
        end else if (s_opt) begin
          prdata_o[7:0] <= opts & `OTPBC_OPT_WMASK;
        end else if (s_stat) begin
          prdata_o[7:0] <= {1'b0, wd_en, green_led_o, red_led_o,
                            compare_output_one_o, mode};
        end
      end
    end
  end

  // Option bits have no reset of any kind.
  always_ff @(posedge clk_i) begin
    if (wr && s_opt && mode != otpbc_pkg::MODE_SINGLE) begin
      opts <= pwdata_i[7:0] & `OTPBC_OPT_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      ppc     <= prot;
      lat     <= 1'b0;
      arm     <= 1'b0;
      clk_opt <= 1'b0;
    end else if (stop_i) begin
      lat <= 1'b0;
      arm <= 1'b0;
    end else if (wr && s_ctrl) begin
      lat     <= pwdata_i[`OTPBC_CTRL_LAT];
      clk_opt <= pwdata_i[`OTPBC_CTRL_CLK];
      if (!pwdata_i[`OTPBC_CTRL_LAT]) begin
        arm <= 1'b0;
      end else if (pwdata_i[`OTPBC_CTRL_ARM] && lat && lat_mask != 4'h0 && !prot) begin
        arm <= 1'b1;
      end
    end
  end
  assign arr_read_ok_o = ~lat;

  always_ff @(posedge clk_i) begin
    if (any_rst || !lat) begin
      lat_mask <= 4'h0;
      lat_addr <= 13'h0000;
      lat_data <= 32'h0000_0000;
    end else if (wr && s_arrw && !arm) begin
      lat_addr <= {pwdata_i[20:10], 2'b00};
      lat_data[8*pwdata_i[9:8] +: 8] <= pwdata_i[7:0];
      if (pwdata_i[20:10] != lat_addr[12:2] && lat_mask != 4'h0) begin
        lat_mask <= 4'h1 << pwdata_i[9:8];
      end else begin
        lat_mask[pwdata_i[9:8]] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      st                   <= otpbc_pkg::S_IDLE;
      cnt                  <= 32'h0000_0000;
      addr                 <= 13'h0000;
      buf_d                <= 32'h0000_0000;
      handshake_line_a_o   <= 1'b0;
      compare_output_one_o <= 1'b0;
      red_led_o            <= 1'b0;
      ld_pulse             <= 1'b0;
    end else begin
      case (st)
        otpbc_pkg::S_IDLE: begin
          cnt <= 32'h0000_0000;
          if (!rise && mode != otpbc_pkg::MODE_SINGLE) begin
            st <= otpbc_pkg::S_COPY;
          end
        end
        otpbc_pkg::S_COPY: begin
          cnt <= cnt + 32'h0000_0001;
          if (cnt == 32'(COPY_CYC - 1)) begin
            compare_output_one_o <= 1'b1;
            addr <= `OTPBC_ARR_LO;
            cnt  <= 32'h0000_0000;
            case (mode)
              otpbc_pkg::MODE_ERASE: st <= otpbc_pkg::S_ERD;
              otpbc_pkg::MODE_PPROG: st <= otpbc_pkg::S_REQ;
              default:               st <= otpbc_pkg::S_HALT;
            endcase
          end
        end
        otpbc_pkg::S_REQ: begin
          handshake_line_a_o <= ~handshake_line_a_o;
          st <= otpbc_pkg::S_WAIT;
        end
        otpbc_pkg::S_WAIT: begin
          if (hsb_s == handshake_line_a_o) begin
            buf_d[8*addr[1:0] +: 8] <= pa_s;
            if (addr[1:0] == 2'b11) begin
              st       <= otpbc_pkg::S_PROG;
              ld_pulse <= 1'b1;
              cnt      <= 32'h0000_0000;
            end else begin
              addr <= addr + 13'h0001;
              st   <= otpbc_pkg::S_REQ;
            end
          end
        end
        otpbc_pkg::S_PROG: begin
          cnt <= cnt + 32'h0000_0001;
          if (cnt == 32'((strap2_q ? PROG_ALT : PROG_CYC) - 1)) begin
            ld_pulse <= 1'b0;
            if (addr == `OTPBC_ARR_HI) begin
              addr <= `OTPBC_ARR_LO;
              st   <= otpbc_pkg::S_VREQ;
            end else begin
              addr <= addr + 13'h0001;
              st   <= otpbc_pkg::S_REQ;
            end
          end
        end
        otpbc_pkg::S_VREQ: begin
          handshake_line_a_o <= ~handshake_line_a_o;
          st <= otpbc_pkg::S_VWAIT;
        end
        otpbc_pkg::S_VWAIT: begin
          if (hsb_s == handshake_line_a_o) begin
            st <= otpbc_pkg::S_VCMP;
          end
        end
        otpbc_pkg::S_VCMP: begin
          if (arr_rdata_i != pa_s) begin
            st <= otpbc_pkg::S_FAIL;
          end else if (addr == `OTPBC_ARR_HI) begin
            st <= otpbc_pkg::S_PASS;
          end else begin
            addr <= addr + 13'h0001;
            st   <= otpbc_pkg::S_VREQ;
          end
        end
        otpbc_pkg::S_ERD: begin
          st <= otpbc_pkg::S_ECMP;
        end
        otpbc_pkg::S_ECMP: begin
          if (arr_rdata_i != 8'h00) begin
            st <= otpbc_pkg::S_FAIL;
          end else if (addr == `OTPBC_ARR_HI) begin
            st <= otpbc_pkg::S_PASS;
          end else begin
            addr <= addr + 13'h0001;
            st   <= otpbc_pkg::S_ERD;
          end
        end
        otpbc_pkg::S_FAIL: begin
          red_led_o <= 1'b1;
        end
        otpbc_pkg::S_PASS: begin
          red_led_o <= 1'b0;
        end
        otpbc_pkg::S_HALT: begin
          st <= otpbc_pkg::S_HALT;
        end
        default: st <= otpbc_pkg::S_IDLE;
      endcase
    end
  end
  assign loader_addr_o = addr;

  // Green blinks while loading, then shows the verdict.
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      blink       <= 32'h0000_0000;
      green_led_o <= 1'b0;
    end else if (st == otpbc_pkg::S_PASS) begin
      green_led_o <= 1'b1;
    end else if (st == otpbc_pkg::S_FAIL) begin
      green_led_o <= 1'b0;
    end else if (st >= otpbc_pkg::S_REQ && st <= otpbc_pkg::S_PROG) begin
      blink <= blink + 32'h0000_0001;
      if (blink == 32'(BLINK_CYC - 1)) begin
        blink       <= 32'h0000_0000;
        green_led_o <= ~green_led_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_o    <= '0;
      prog_en_o <= 1'b0;
    end else begin
      prog_en_o <= (arm | ld_pulse) & ~prot;
      if (st == otpbc_pkg::S_PROG) begin
        prog_o <= '{addr: {addr[12:2], 2'b00}, data: buf_d, mask: 4'hf};
      end else begin
        prog_o <= '{addr: lat_addr, data: lat_data, mask: lat_mask};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_bit7_zero;
    ack && s_ctrl && !pwrite_i |-> prdata_o[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 read one");

  property p_ppc_reload;
    !ext_n_s |=> ppc == $past(prot);
  endproperty
  a_ppc_reload: assert property (p_ppc_reload) else $error("copy not reloaded");

  property p_stop_clears;
    stop_i && !any_rst |=> !lat && !arm;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop kept latch");

  property p_arm_cause;
    $rose(arm) |-> $past(lat) && $past(lat_mask) != 4'h0;
  endproperty
  a_arm_cause: assert property (p_arm_cause) else $error("arm without latch");

  property p_arm_follows;
    !lat |-> !arm;
  endproperty
  a_arm_follows: assert property (p_arm_follows) else $error("arm outlived latch");

  property p_opt_locked;
    mode == otpbc_pkg::MODE_SINGLE |=> $stable(opts);
  endproperty
  a_opt_locked: assert property (p_opt_locked) else $error("option changed");

  property p_protect;
    prot && $past(prot) |-> !prog_en_o;
  endproperty
  a_protect: assert property (p_protect) else $error("program while protected");

  property p_wait_halt;
    wait_i && !opts[`OTPBC_OPT_WDW] |-> !watchdog_run_o;
  endproperty
  a_wait_halt: assert property (p_wait_halt) else $error("watchdog ran in wait");

  property p_erase_fail;
    st == otpbc_pkg::S_ECMP && arr_rdata_i != 8'h00 |=> st == otpbc_pkg::S_FAIL ##1 red_led_o;
  endproperty
  a_erase_fail: assert property (p_erase_fail) else $error("erase miss");

  c_arm: cover property ($rose(arm));
  c_pass: cover property (st == otpbc_pkg::S_PASS);
  c_fail: cover property (st == otpbc_pkg::S_FAIL);
endmodule

// ### otpbc_source.sv
// Model of the external parallel data source that feeds the loader.
// Assumes the loader address and request line are timed by the same clock.
`timescale 1ns/1ps
module otpbc_source (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Loader side.
  input  wire logic [12:0] addr_i,
  input  wire logic        req_i,
  output logic [7:0]       data_o,
  output logic             ack_o
);
  logic last;
  int   dly;
  // Byte held at an address; the top segment is kept, so it supplies zero.
  function automatic logic [7:0] src_byte(input logic [12:0] a);
    return (a[12:8] == 5'h1f) ? 8'h00 : (a[7:0] ^ {a[12:8], 3'b101});
  endfunction
  // A new request waits a random time with changing junk on the data lines.
  always @(posedge clk_i) begin
    if (rst_i) begin
      last   <= 1'b0;
      ack_o  <= 1'b0;
      dly    <= 0;
    end else if (req_i !== last) begin
      last   <= req_i;
      dly    <= $urandom_range(5, 1);
      data_o <= ~data_o;
    end else if (dly > 1) begin
      dly    <= dly - 1;
      data_o <= ~data_o;
    end else if (dly == 1) begin
      dly    <= 0;
      data_o <= src_byte(addr_i);
    end else begin
      ack_o  <= last;
    end
  end
endmodule

// ### test_otp_program_control_and_boot_modes.sv
// Self-checking bench for the programming control and boot mode block.
// Assumes the header, package, design and source model are compiled first.
`timescale 1ns/1ps
`include "otpbc_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_otp_program_control_and_boot_modes;
  localparam int          PROG   = 20;
  localparam logic [15:0] A_CTRL = {`OTPBC_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_OPT  = {`OTPBC_IDX_OPT, 2'b00};
  localparam logic [15:0] A_ARR  = {`OTPBC_IDX_ARRW, 2'b00};
  localparam logic [15:0] A_STAT = {`OTPBC_IDX_STAT, 2'b00};
  logic                   clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic [15:0]            paddr_i;
  logic [31:0]            pwdata_i, prdata_o, rd;
  logic                   ext_reset_n_i, irq_hv_i, capture_input_one_i, stop_i, wait_i, bad_on;
  logic [2:0]             mode_strap_i;
  logic [7:0]             ddr_b_i, ddr_c_i, pulldown_b_o, pulldown_c_o, port_a_i, arr_rdata_i;
  logic                   reset_pin_low_o, watchdog_enable_o, watchdog_run_o, handshake_line_b_i;
  logic                   handshake_line_a_o, compare_output_one_o, red_led_o, green_led_o;
  logic                   arr_read_ok_o, prog_en_o, hs_prev, g_prev;
  logic [12:0]            loader_addr_o, a;
  logic [10:0]            g;
  logic [1:0]             b;
  logic [7:0]             d;
  otpbc_pkg::otpbc_mode_t boot_mode_o;
  otpbc_pkg::otpbc_prog_t prog_o;
  otpbc_pkg::otpbc_prog_t grp_q[$];
  logic [12:0]            req_q[$];
  int                     len_q[$];
  int                     fail_count, samples_checked, plen, g_toggles, g_base, hold, i;
  logic [3:0]             tbl [5] = '{4'b1110, 4'b1100, 4'b1011, 4'b0000, 4'b1000};
  otpbc_pkg::otpbc_mode_t tbl_m [5] = '{otpbc_pkg::MODE_SERIAL, otpbc_pkg::MODE_RAMPAR,
    otpbc_pkg::MODE_SINGLE, otpbc_pkg::MODE_SINGLE, otpbc_pkg::MODE_PPROG};
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_byte(input logic [12:0] x);
    return (x[12:8] == 5'h1f) ? 8'h00 : (x[7:0] ^ {x[12:8], 3'b101});
  endfunction
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic wait_until(input int sel, input int lim);
    int   n;
    logic hit;
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      case (sel)
        0: hit = green_led_o;
        1: hit = red_led_o;
        3: hit = (len_q.size() >= 3);
        4: hit = prog_en_o;
        default: hit = compare_output_one_o;
      endcase
      if (hit === 1'b1) return;
    end
    fail_count++;
    summarize();
  endtask
  task automatic power_on(input logic [2:0] s, input logic hv, input logic cap);
    {rst_i, mode_strap_i, irq_hv_i, capture_input_one_i} <= {1'b1, s, hv, cap};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (hold = 0; hold < 5000; hold++) begin
      @(posedge clk_i);
      if (reset_pin_low_o !== 1'b1) break;
    end
    repeat (4) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  otpbc_top #(.PROG_CYC(PROG), .PROG_ALT(PROG), .BLINK_CYC(8), .COPY_CYC(64)) u_dut (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .ext_reset_n_i, .irq_hv_i, .capture_input_one_i, .mode_strap_i, .stop_i,
    .wait_i, .ddr_b_i, .ddr_c_i, .reset_pin_low_o, .watchdog_enable_o, .watchdog_run_o,
    .pulldown_b_o, .pulldown_c_o, .boot_mode_o, .port_a_i, .handshake_line_b_i,
    .loader_addr_o, .handshake_line_a_o, .compare_output_one_o, .red_led_o, .green_led_o,
    .arr_rdata_i, .arr_read_ok_o, .prog_o, .prog_en_o);
  otpbc_source u_src (.clk_i, .rst_i, .addr_i(loader_addr_o), .req_i(handshake_line_a_o),
    .data_o(port_a_i), .ack_o(handshake_line_b_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Array model with one cycle of read latency, plus loader monitors.
  always @(posedge clk_i) begin
    arr_rdata_i <= (bad_on && loader_addr_o == 13'h0105) ? 8'h3c : 8'h00;
    hs_prev <= handshake_line_a_o;
    g_prev <= green_led_o;
    if (handshake_line_a_o !== hs_prev) req_q.push_back(loader_addr_o);
    if (green_led_o !== g_prev) g_toggles++;
    if (prog_en_o === 1'b1 && plen == 0) grp_q.push_back(prog_o);
    if (prog_en_o === 1'b1) plen <= plen + 1;
    else if (plen != 0) begin
      len_q.push_back(plen);
      plen <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel_i, penable_i, pwrite_i, stop_i, wait_i, bad_on, paddr_i, pwdata_i} = '0;
    {ext_reset_n_i, rst_i, mode_strap_i, irq_hv_i, capture_input_one_i} = 7'b1100000;
    {ddr_b_i, ddr_c_i} = '0;
    {fail_count, samples_checked} = '0;
    void'($urandom(32'h8809));
    // Plain power-on into single chip, control register handling.
    power_on(3'b000, 1'b0, 1'b0);
    `CHK(hold inside {[4064:4067]}, 1'b1)
    `CHK(boot_mode_o, otpbc_pkg::MODE_SINGLE)
    ddr_b_i <= 8'($urandom);
    ddr_c_i <= 8'($urandom);
    apb(0, A_CTRL, 0);
    `CHK(rd, 32'h0000_0000)
    apb(1, A_CTRL, 32'h0000_00b8);
    apb(0, A_CTRL, 0);
    `CHK(rd, 32'h0000_0028)
    `CHK({arr_read_ok_o, pulldown_b_o, pulldown_c_o}, 17'h0_0000)
    g = 11'h040 + 11'($urandom_range(1983));
    b = 2'($urandom);
    d = 8'($urandom);
    apb(1, A_ARR, {11'h000, g, b, d});
    repeat (2) @(posedge clk_i);
    `CHK({prog_o.addr[12:2], prog_o.data[8*b +: 8], prog_o.mask}, {g, d, 4'b0001 << b})
    apb(1, A_CTRL, 32'h0000_0030);
    wait_until(4, 10);
    apb(0, A_CTRL, 0);
    `CHK(rd[7:0], 8'h30)
    apb(1, A_CTRL, 32'h0000_0020);
    apb(0, A_CTRL, 0);
    `CHK(rd[7:0], 8'h30)
    apb(1, A_CTRL, 32'h0000_0000);
    apb(0, A_CTRL, 0);
    `CHK({rd[7:0], arr_read_ok_o}, 9'h001)
    apb(1, A_CTRL, 32'h0000_0020);
    @(posedge clk_i);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    apb(0, A_CTRL, 0);
    `CHK(rd[7:0], 8'h00)
    apb(1, A_OPT, 32'h0000_005b);
    apb(0, A_OPT, 0);
    `CHK(rd, 32'h0000_0000)
    apb(0, 16'h0100, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
    // Erased check that succeeds; options are written in bootloader mode.
    power_on(3'b010, 1'b1, 1'b1);
    `CHK(hold inside {[4064:4067]}, 1'b1)
    `CHK({boot_mode_o, watchdog_enable_o, compare_output_one_o}, 5'b00100)
    apb(1, A_OPT, 32'h0000_005b);
    apb(0, A_OPT, 0);
    `CHK(rd, 32'h0000_005b)
    wait_until(5, 300);
    wait_until(0, 60000);
    apb(0, A_STAT, 0);
    `CHK(rd[6:0], 7'h29)
    // Single chip with protection, short hold and watchdog options.
    power_on(3'b000, 1'b0, 1'b0);
    `CHK(hold inside {[16:19]}, 1'b1)
    apb(0, A_OPT, 0);
    `CHK(rd[7:0], 8'h5b)
    apb(0, A_CTRL, 0);
    `CHK(rd[7:0], 8'h40)
    `CHK({pulldown_b_o, pulldown_c_o}, ~{ddr_b_i, ddr_c_i})
    wait_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK({watchdog_enable_o, watchdog_run_o}, 2'b10)
    wait_i <= 1'b0;
    apb(1, A_CTRL, 32'h0000_0020);
    apb(1, A_ARR, 32'h0001_0011);
    apb(1, A_CTRL, 32'h0000_0030);
    repeat (10) @(posedge clk_i);
    apb(0, A_CTRL, 0);
    `CHK({rd[7:0], prog_en_o}, 9'h0c0)
    ext_reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    apb(0, A_CTRL, 0);
    `CHK(rd[7:0], 8'h40)
    // Erased check that meets a nonzero byte.
    bad_on <= 1'b1;
    power_on(3'b010, 1'b1, 1'b1);
    `CHK(watchdog_enable_o, 1'b0)
    apb(1, A_OPT, 32'h0000_001f);
    wait_until(1, 3000);
    `CHK(green_led_o, 1'b0)
    bad_on <= 1'b0;
    // Every remaining mode, ending in the parallel loader.
    for (i = 0; i < 5; i++) begin
      power_on(tbl[i][2:0], 1'b1, tbl[i][3]);
      `CHK(boot_mode_o, tbl_m[i])
      req_q.delete();
      grp_q.delete();
      len_q.delete();
      g_base = g_toggles;
    end
    wait_until(3, 3000);
    for (i = 0; i < 12; i++) `CHK(req_q[i], 13'h0100 + 13'(i))
    for (i = 0; i < 3; i++) begin
      a = 13'h0100 + 13'(4 * i);
      `CHK(grp_q[i].addr[12:2], a[12:2])
      `CHK(grp_q[i].data, {exp_byte(a + 3), exp_byte(a + 2), exp_byte(a + 1), exp_byte(a)})
      `CHK(len_q[i], PROG)
    end
    `CHK(g_toggles > g_base, 1'b1)
    summarize();
  end
endmodule
